// >>> epsc_command_port.sv
`timescale 1ns/100ps

module epsc_command_port #(
    parameter int unsigned BOOT_CYCLES   = epsc_pkg::BOOT_BUSY_CYCLES,
    parameter logic [7:0]  SRC_LOW_RESET = 8'h00
) (
    input  wire logic        sys_clk,
    input  wire logic        reset,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        spi_sclk,
    input  wire logic        spi_sda,
    input  wire logic        host_sel_n,
    input  wire logic        dc_sel,
    input  wire logic        hw_reset_n,
    input  wire logic        bus_width_strap,
    output logic             busy,
    output logic             first_gate_sel,
    output logic             gate_interlace_sel,
    output logic             scan_reverse,
    output logic      [4:0]  gate_high_level,
    output logic      [7:0]  source_high_level_one,
    output logic      [7:0]  source_high_level_two,
    output logic      [7:0]  source_low_level
);

    localparam int unsigned BOOT_W = $clog2(BOOT_CYCLES + 1);
    localparam logic [BOOT_W-1:0] BOOT_LOAD = BOOT_W'(BOOT_CYCLES);
    localparam logic [BOOT_W-1:0] BOOT_ZERO = '0;

    // Pin and link toggle synchronisers
    logic hwrst_s1_q;
    logic hwrst_s2_q;
    logic strap_s1_q;
    logic strap_s2_q;
    logic tog_s1_q;
    logic tog_s2_q;
    logic tog_s3_q;

    // Internal reset and mode
    logic              int_rst;
    logic              int_rst_q;
    logic              mode_3wire_q;
    logic [BOOT_W-1:0] boot_cnt_q;
    logic [BOOT_W-1:0] boot_cnt_d;

    // Link receiver outputs
    logic [7:0] rx_byte;
    logic       rx_dc;
    logic       rx_toggle;
    logic       rx_event;
    logic       rx_take;
    logic       rx_cmd;
    logic       rx_param;

    // Interpreter state
    logic [7:0]  cmd_q;
    logic [1:0]  param_idx_q;
    logic [8:0]  gate_mux_q;
    logic [2:0]  gate_scan_q;
    logic [4:0]  gate_high_q;
    logic [7:0]  src_one_q;
    logic [7:0]  src_two_q;
    logic [7:0]  src_low_q;
    logic [15:0] byte_cnt_q;
    logic        refused_q;
    logic        refused_d;

    // Software control
    logic [1:0] ctrl_q;
    logic       busy_d;

    // Bus state
    logic        ap_valid;
    logic        dp_write_q;
    logic [7:0]  dp_addr_q;
    logic [31:0] rd_mux;
    logic        wr_status;
    logic        wr_control;

    always_ff @(posedge sys_clk) begin
        hwrst_s1_q <= hw_reset_n;
        hwrst_s2_q <= hwrst_s1_q;
        strap_s1_q <= bus_width_strap;
        strap_s2_q <= strap_s1_q;
    end

    // Cleared with the link side, so no false byte event follows any reset
    always_ff @(posedge sys_clk) begin
        if (int_rst) begin
            tog_s1_q <= 1'b0;
            tog_s2_q <= 1'b0;
            tog_s3_q <= 1'b0;
        end else begin
            tog_s1_q <= rx_toggle;
            tog_s2_q <= tog_s1_q;
            tog_s3_q <= tog_s2_q;
        end
    end

    // The pin reset and the system reset both clear the command state
    assign int_rst = reset | ~hwrst_s2_q;

    always_ff @(posedge sys_clk) begin
        int_rst_q <= int_rst;
    end

    // Strap is caught at the release; it must stay put while frames run
    always_ff @(posedge sys_clk) begin
        if (int_rst_q && !int_rst) begin
            mode_3wire_q <= strap_s2_q;
        end else if (reset) begin
            mode_3wire_q <= 1'b0;
        end
    end

    epsc_frame_rx u_frame_rx (
        .spi_sclk    (spi_sclk),
        .link_rst    (int_rst_q),
        .host_sel_n  (host_sel_n),
        .spi_sda     (spi_sda),
        .dc_sel      (dc_sel),
        .mode_3wire  (mode_3wire_q),
        .rx_byte_q   (rx_byte),
        .rx_dc_q     (rx_dc),
        .rx_toggle_q (rx_toggle)
    );

    // Byte data hold until the next frame, far longer than the toggle crossing
    assign rx_event = tog_s2_q ^ tog_s3_q;
    assign rx_take  = rx_event & ~busy;
    assign rx_cmd   = rx_take & ~rx_dc;
    assign rx_param = rx_take & rx_dc;

    always_ff @(posedge sys_clk) begin
        if (int_rst) begin
            cmd_q       <= 8'h00;
            param_idx_q <= epsc_pkg::PARAM_FIRST;
        end else if (rx_cmd) begin
            cmd_q       <= rx_byte;
            param_idx_q <= epsc_pkg::PARAM_FIRST;
        end else if (rx_param && param_idx_q != epsc_pkg::PARAM_THIRD) begin
            param_idx_q <= param_idx_q + 2'h1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (int_rst) begin
            gate_mux_q  <= epsc_pkg::GATE_MUX_RESET;
            gate_scan_q <= epsc_pkg::GATE_SCAN_RESET;
        end else if (rx_param && cmd_q == epsc_pkg::CMD_DRIVER_OUT) begin
            unique case (param_idx_q)
                epsc_pkg::PARAM_FIRST: begin
                    gate_mux_q[7:0] <= rx_byte;
                end
                epsc_pkg::PARAM_SECOND: begin
                    gate_mux_q[8] <= rx_byte[0];
                end
                default: begin
                    gate_scan_q <= rx_byte[2:0];
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (int_rst) begin
            gate_high_q <= epsc_pkg::GATE_HIGH_RESET;
        end else if (rx_param && cmd_q == epsc_pkg::CMD_GATE_VOLT && param_idx_q == epsc_pkg::PARAM_FIRST) begin
            gate_high_q <= rx_byte[4:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (int_rst) begin
            src_one_q <= epsc_pkg::SRC_ONE_RESET;
            src_two_q <= epsc_pkg::SRC_TWO_RESET;
            src_low_q <= SRC_LOW_RESET;
        end else if (rx_param && cmd_q == epsc_pkg::CMD_SOURCE_VOLT) begin
            unique case (param_idx_q)
                epsc_pkg::PARAM_FIRST: begin
                    src_one_q <= rx_byte;
                end
                epsc_pkg::PARAM_SECOND: begin
                    src_two_q <= rx_byte;
                end
                default: begin
                    src_low_q <= rx_byte;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (int_rst) begin
            byte_cnt_q <= 16'h0000;
        end else if (rx_take) begin
            byte_cnt_q <= byte_cnt_q + 16'h0001;
        end
    end

    // Busy holds through reset and a settle time after it, then follows the work flags
    assign boot_cnt_d = int_rst ? BOOT_LOAD :
                        (boot_cnt_q != BOOT_ZERO) ? boot_cnt_q - {{(BOOT_W-1){1'b0}}, 1'b1} : BOOT_ZERO;
    assign busy_d     = int_rst | (boot_cnt_d != BOOT_ZERO) | ctrl_q[epsc_pkg::CTL_WAVE_BIT]
                      | ctrl_q[epsc_pkg::CTL_TEMP_BIT];

    always_ff @(posedge sys_clk) begin
        boot_cnt_q <= boot_cnt_d;
        busy       <= busy_d;
    end

    // AHB-Lite slave, zero wait states
    assign ap_valid   = hsel & hready & (htrans == epsc_pkg::HTRANS_NONSEQ);
    assign wr_status  = dp_write_q & (dp_addr_q == epsc_pkg::REG_STATUS);
    assign wr_control = dp_write_q & (dp_addr_q == epsc_pkg::REG_CONTROL);

    // A byte refused while busy leaves a sticky flag; a new refusal beats the clear
    assign refused_d = (rx_event & busy) ? 1'b1 :
                       (wr_status && hwdata[epsc_pkg::ST_REFUSED_BIT]) ? 1'b0 : refused_q;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            refused_q <= 1'b0;
            ctrl_q    <= 2'b00;
        end else begin
            refused_q <= refused_d;
            if (wr_control) begin
                ctrl_q <= {hwdata[epsc_pkg::CTL_TEMP_BIT], hwdata[epsc_pkg::CTL_WAVE_BIT]};
            end
        end
    end

    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (haddr[7:0])
            epsc_pkg::REG_STATUS: begin
                rd_mux[epsc_pkg::ST_BUSY_BIT]               = busy;
                rd_mux[epsc_pkg::ST_MODE_BIT]               = mode_3wire_q;
                rd_mux[epsc_pkg::ST_REFUSED_BIT]            = refused_q;
                rd_mux[epsc_pkg::ST_RESET_BIT]              = int_rst_q;
                rd_mux[epsc_pkg::ST_CMD_LSB +: 8]           = cmd_q;
            end
            epsc_pkg::REG_CONTROL: begin
                rd_mux[epsc_pkg::CTL_WAVE_BIT]              = ctrl_q[0];
                rd_mux[epsc_pkg::CTL_TEMP_BIT]              = ctrl_q[1];
            end
            epsc_pkg::REG_GATE_CFG: begin
                rd_mux[8:0]                                 = gate_mux_q;
                rd_mux[epsc_pkg::GATE_SCAN_LSB +: 3]        = gate_scan_q;
            end
            epsc_pkg::REG_VOLT_CFG: begin
                rd_mux[4:0]                                 = gate_high_q;
            end
            epsc_pkg::REG_SRC_CFG: begin
                rd_mux[7:0]                                 = src_one_q;
                rd_mux[epsc_pkg::SRC_TWO_LSB +: 8]          = src_two_q;
                rd_mux[epsc_pkg::SRC_LOW_LSB +: 8]          = src_low_q;
            end
            epsc_pkg::REG_BYTE_CNT: begin
                rd_mux[15:0]                                = byte_cnt_q;
            end
            default: begin
                rd_mux = 32'h0000_0000;
            end
        endcase
        if (haddr[31:8] != 24'h00_0000) begin
            rd_mux = 32'h0000_0000;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            dp_write_q <= 1'b0;
            dp_addr_q  <= 8'h00;
            hrdata     <= 32'h0000_0000;
            hreadyout  <= 1'b0;
            hresp      <= epsc_pkg::HRESP_OKAY;
        end else begin
            dp_write_q <= ap_valid & hwrite & (haddr[31:8] == 24'h00_0000);
            dp_addr_q  <= haddr[7:0];
            hreadyout  <= 1'b1;
            hresp      <= epsc_pkg::HRESP_OKAY;
            if (ap_valid && !hwrite) begin
                hrdata <= rd_mux;
            end
        end
    end

    // Scan settings drive the gate sequencer outside this block
    always_ff @(posedge sys_clk) begin
        first_gate_sel        <= gate_scan_q[epsc_pkg::SCAN_FIRST_GATE_BIT];
        gate_interlace_sel    <= gate_scan_q[epsc_pkg::SCAN_INTERLACE_BIT];
        scan_reverse          <= gate_scan_q[epsc_pkg::SCAN_REVERSE_BIT];
        gate_high_level       <= gate_high_q;
        source_high_level_one <= src_one_q;
        source_high_level_two <= src_two_q;
        source_low_level      <= src_low_q;
    end

endmodule

// >>> epsc_pkg.sv
package epsc_pkg;

    // Clock and timing
    localparam int unsigned SYS_CLK_MHZ      = 100;
    localparam int unsigned BOOT_BUSY_NS     = 1000;
    localparam int unsigned BOOT_BUSY_CYCLES =
        ((BOOT_BUSY_NS * SYS_CLK_MHZ + 999) / 1000 < 1) ? 1 : (BOOT_BUSY_NS * SYS_CLK_MHZ + 999) / 1000;

    // Frame lengths
    localparam logic [3:0] FRAME_BITS_4WIRE = 4'h8;
    localparam logic [3:0] FRAME_BITS_3WIRE = 4'h9;

    // Command codes
    localparam logic [7:0] CMD_DRIVER_OUT  = 8'h01;
    localparam logic [7:0] CMD_GATE_VOLT   = 8'h03;
    localparam logic [7:0] CMD_SOURCE_VOLT = 8'h04;

    // Parameter positions inside a command
    localparam logic [1:0] PARAM_FIRST  = 2'h0;
    localparam logic [1:0] PARAM_SECOND = 2'h1;
    localparam logic [1:0] PARAM_THIRD  = 2'h2;

    // Reset values
    localparam logic [8:0] GATE_MUX_RESET  = 9'h0_c7;
    localparam logic [2:0] GATE_SCAN_RESET = 3'h0;
    localparam logic [4:0] GATE_HIGH_RESET = 5'h00;
    localparam logic [7:0] SRC_ONE_RESET   = 8'h41;
    localparam logic [7:0] SRC_TWO_RESET   = 8'ha8;

    // Gate scan field bit positions
    localparam int unsigned SCAN_FIRST_GATE_BIT = 2;
    localparam int unsigned SCAN_INTERLACE_BIT  = 1;
    localparam int unsigned SCAN_REVERSE_BIT    = 0;

    // Register byte offsets
    localparam logic [7:0] REG_STATUS   = 8'h00;
    localparam logic [7:0] REG_CONTROL  = 8'h04;
    localparam logic [7:0] REG_GATE_CFG = 8'h08;
    localparam logic [7:0] REG_VOLT_CFG = 8'h0c;
    localparam logic [7:0] REG_SRC_CFG  = 8'h10;
    localparam logic [7:0] REG_BYTE_CNT = 8'h14;

    // Status, control, gate and source field positions
    localparam int unsigned ST_BUSY_BIT    = 0;
    localparam int unsigned ST_MODE_BIT    = 1;
    localparam int unsigned ST_REFUSED_BIT = 2;
    localparam int unsigned ST_RESET_BIT   = 3;
    localparam int unsigned ST_CMD_LSB     = 8;
    localparam int unsigned CTL_WAVE_BIT   = 0;
    localparam int unsigned CTL_TEMP_BIT   = 1;
    localparam int unsigned GATE_SCAN_LSB  = 16;
    localparam int unsigned SRC_TWO_LSB    = 8;
    localparam int unsigned SRC_LOW_LSB    = 16;

    // AHB encodings
    localparam logic [1:0] HTRANS_IDLE   = 2'h0;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic       HRESP_OKAY    = 1'h0;

endpackage

// >>> epsc_frame_rx.sv
`timescale 1ns/100ps

// Link-domain shifter: one frame per byte, most significant bit first
module epsc_frame_rx (
    input  wire logic       spi_sclk,
    input  wire logic       link_rst,
    input  wire logic       host_sel_n,
    input  wire logic       spi_sda,
    input  wire logic       dc_sel,
    input  wire logic       mode_3wire,
    output logic      [7:0] rx_byte_q,
    output logic            rx_dc_q,
    output logic            rx_toggle_q
);

    logic [7:0] shift_q;
    logic [3:0] bit_cnt_q;
    logic [3:0] last_bit;
    logic       frame_clr;
    logic       frame_done;

    // The link clock stops between frames, so the bit count is ended by the select itself
    assign frame_clr  = host_sel_n | link_rst;
    assign last_bit   = mode_3wire ? (epsc_pkg::FRAME_BITS_3WIRE - 4'h1)
                                   : (epsc_pkg::FRAME_BITS_4WIRE - 4'h1);
    assign frame_done = (bit_cnt_q == last_bit);

    always_ff @(posedge spi_sclk or posedge frame_clr) begin
        if (frame_clr) begin
            bit_cnt_q <= 4'h0;
        end else if (frame_done) begin
            bit_cnt_q <= 4'h0;
        end else begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
        end
    end

    // Sampled on every rising edge, whether selected or not
    always_ff @(posedge spi_sclk) begin
        shift_q <= {shift_q[6:0], spi_sda};
    end

    always_ff @(posedge spi_sclk or posedge link_rst) begin
        if (link_rst) begin
            rx_byte_q   <= 8'h00;
            rx_dc_q     <= 1'b0;
            rx_toggle_q <= 1'b0;
        end else if (!host_sel_n && frame_done) begin
            // In 9-bit frames the leading bit sits at shift_q[7] and carries the flag
            rx_byte_q   <= {shift_q[6:0], spi_sda};
            rx_dc_q     <= mode_3wire ? shift_q[7] : dc_sel;
            rx_toggle_q <= ~rx_toggle_q;
        end
    end

endmodule

// >>> epsc_command_port_assertions.sv
`timescale 1ns/100ps
module epsc_command_port_checker #(
    parameter int unsigned BOOT_CYCLES = 100
) (
    input wire logic        sys_clk,
    input wire logic        reset,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        hw_reset_n,
    input wire logic        busy,
    input wire logic        first_gate_sel,
    input wire logic        gate_interlace_sel,
    input wire logic        scan_reverse,
    input wire logic [4:0]  gate_high_level,
    input wire logic [7:0]  source_high_level_one,
    input wire logic [7:0]  source_high_level_two
);
    localparam int BOOT_MAX = BOOT_CYCLES + 8;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    wire logic       taken    = hsel && hready && htrans == epsc_pkg::HTRANS_NONSEQ;
    wire logic       rd_taken = taken && !hwrite;
    wire logic       wr_ctl   = taken && hwrite && haddr == {24'h00_0000, epsc_pkg::REG_CONTROL};
    wire logic [2:0] scan     = {first_gate_sel, gate_interlace_sel, scan_reverse};

    chk_boot_busy: assert property ($fell(reset) |-> busy [*4] ##[1:BOOT_MAX] !busy)
        else $error("busy did not hold then clear after reset");
    chk_reset_values: assert property ($fell(reset) |-> scan == 3'h0 && gate_high_level == 5'h00
        && source_high_level_one == 8'h41 && source_high_level_two == 8'ha8)
        else $error("settings not at reset values");
    chk_pin_reset_busy: assert property ((!hw_reset_n) [*4] ##1 hw_reset_n |-> busy [*6])
        else $error("busy low during pin reset");
    chk_work_busy: assert property (wr_ctl ##1 hwdata[1:0] != 2'h0 |-> ##[1:3] busy)
        else $error("busy not raised by internal work");
    chk_zero_wait: assert property (!$past(reset) |-> hreadyout && hresp == epsc_pkg::HRESP_OKAY)
        else $error("bus not ready or not okay");
    chk_read_holds: assert property (hw_reset_n && $past(hw_reset_n, 4) && !$past(rd_taken) |-> $stable(hrdata))
        else $error("read data changed without a read");
    chk_unmapped_zero: assert property (rd_taken && haddr[31:8] != 24'h00_0000 |=> hrdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    chk_src_readback: assert property (rd_taken && haddr == {24'h00_0000, epsc_pkg::REG_SRC_CFG}
        |=> hrdata[15:0] == {source_high_level_two, source_high_level_one})
        else $error("source levels differ from register");
    chk_gate_readback: assert property (rd_taken && haddr == {24'h00_0000, epsc_pkg::REG_GATE_CFG}
        |=> hrdata[18:16] == scan)
        else $error("scan field differs from register");
endmodule

bind epsc_command_port epsc_command_port_checker #(.BOOT_CYCLES(BOOT_CYCLES)) chk_i (
    .sys_clk(sys_clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .hw_reset_n(hw_reset_n), .busy(busy), .first_gate_sel(first_gate_sel),
    .gate_interlace_sel(gate_interlace_sel), .scan_reverse(scan_reverse), .gate_high_level(gate_high_level),
    .source_high_level_one(source_high_level_one), .source_high_level_two(source_high_level_two)
);

// >>> epsc_host_model.sv
`timescale 1ns/100ps
// Serial clock stands low between frames
module epsc_host_model (
    input  wire logic three_wire,
    input  wire logic ignore_busy,
    input  wire logic busy,
    output logic      spi_sclk,
    output logic      spi_sda,
    output logic      host_sel_n,
    output logic      dc_sel
);
    initial begin
        spi_sclk   = 1'b0;
        spi_sda    = 1'b0;
        dc_sel     = 1'b0;
        // Select rises after time zero so the link bit counter surely sees its clearing edge
        #1;
        host_sel_n = 1'b1;
    end

    task automatic send(input logic dc, input logic [7:0] data, input logic sel);
        logic [8:0] frame;
        int         nbits;
        frame = {dc, data};
        nbits = three_wire ? 9 : 8;
        while (busy !== 1'b0 && ignore_busy !== 1'b1) begin
            #100;
        end
        #37;
        host_sel_n = ~sel;
        // Pin is unused in 3-wire mode; the opposite value exposes a design that reads it
        dc_sel = three_wire ? ~dc : dc;
        for (int i = nbits - 1; i >= 0; i--) begin
            spi_sda = frame[i];
            #20 spi_sclk = 1'b1;
            #40 spi_sclk = 1'b0;
            #20;
        end
        host_sel_n = 1'b1;
        // Released lines must not keep the last bit
        spi_sda = ~spi_sda;
        dc_sel  = ~dc_sel;
        #1000;
    endtask
endmodule

// >>> epaper_spi_command_port_test.sv
`timescale 1ns/100ps
module epaper_spi_command_port_test;
    logic        sys_clk = 1'b0;
    logic        reset = 1'b1;
    logic        hsel = 1'b0;
    logic        hwrite = 1'b0;
    logic        hw_reset_n = 1'b1;
    logic        bus_width_strap = 1'b0;
    logic        three_wire = 1'b0;
    logic        ignore_busy = 1'b0;
    logic [1:0]  htrans = epsc_pkg::HTRANS_IDLE;
    logic [31:0] haddr = 32'h0000_0000;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [31:0] hrdata, rd;
    logic        hreadyout, busy, spi_sclk, spi_sda, host_sel_n, dc_sel;
    logic        first_gate_sel, gate_interlace_sel, scan_reverse;
    logic [4:0]  gate_high_level;
    logic [7:0]  src_one, src_two, src_low;
    int          n_errors = 0;
    int          check_count = 0;

    always #5 sys_clk = ~sys_clk;

    epsc_command_port #(.BOOT_CYCLES(8)) uut (
        .sys_clk(sys_clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(),
        .spi_sclk(spi_sclk), .spi_sda(spi_sda), .host_sel_n(host_sel_n), .dc_sel(dc_sel),
        .hw_reset_n(hw_reset_n), .bus_width_strap(bus_width_strap), .busy(busy),
        .first_gate_sel(first_gate_sel), .gate_interlace_sel(gate_interlace_sel), .scan_reverse(scan_reverse),
        .gate_high_level(gate_high_level), .source_high_level_one(src_one), .source_high_level_two(src_two),
        .source_low_level(src_low)
    );

    epsc_host_model host (
        .three_wire(three_wire), .ignore_busy(ignore_busy), .busy(busy), .spi_sclk(spi_sclk),
        .spi_sda(spi_sda), .host_sel_n(host_sel_n), .dc_sel(dc_sel)
    );

    function automatic logic [31:0] ra(input logic [7:0] off);
        return {24'h00_0000, off};
    endfunction

    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rdat);
        @(posedge sys_clk);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= epsc_pkg::HTRANS_NONSEQ;
        hwrite <= wr;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        htrans <= epsc_pkg::HTRANS_IDLE;
        hwdata <= wd;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        rdat = hrdata;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rd_check(input logic [31:0] a, input logic [31:0] exp);
        ahb(1'b0, a, 32'h0000_0000, rd);
        check(rd, exp);
    endtask

    task automatic st_check(input logic [3:0] exp);
        ahb(1'b0, ra(epsc_pkg::REG_STATUS), 32'h0000_0000, rd);
        check({28'h000_0000, rd[3:0]}, {28'h000_0000, exp});
    endtask

    // Pin order: source low, scan field, gate high, source one, source two
    task automatic pins_check(input logic [31:0] exp);
        check({src_low, first_gate_sel, gate_interlace_sel, scan_reverse, gate_high_level, src_one, src_two}, exp);
    endtask

    task automatic wait_ready;
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 1000) begin
            @(posedge sys_clk);
            n++;
        end
        check({31'h0000_0000, busy}, 32'h0000_0000);
    endtask

    task automatic cmd3(input logic [7:0] c, input logic [7:0] p0, input logic [7:0] p1, input logic [7:0] p2);
        host.send(1'b0, c, 1'b1);
        host.send(1'b1, p0, 1'b1);
        host.send(1'b1, p1, 1'b1);
        host.send(1'b1, p2, 1'b1);
    endtask

    task automatic complete_run;
        $display("comparisons %0d, mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        #400_000;
        n_errors++;
        complete_run();
    end

    initial begin
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
        wait_ready();
        rd_check(ra(epsc_pkg::REG_GATE_CFG), 32'h0000_00c7);
        rd_check(ra(epsc_pkg::REG_VOLT_CFG), 32'h0000_0000);
        rd_check(ra(epsc_pkg::REG_SRC_CFG), 32'h0000_a841);
        pins_check(32'h0000_41a8);
        st_check(4'h0);
        rd_check(32'h0000_0100, 32'h0000_0000);
        ahb(1'b1, ra(epsc_pkg::REG_SRC_CFG), 32'h0000_1234, rd);
        rd_check(ra(epsc_pkg::REG_SRC_CFG), 32'h0000_a841);
        cmd3(8'h01, 8'hc7, 8'h00, 8'h05);
        pins_check(32'h00a0_41a8);
        cmd3(8'h01, 8'h63, 8'h01, 8'h02);
        pins_check(32'h0040_41a8);
        rd_check(ra(epsc_pkg::REG_GATE_CFG), 32'h0002_0163);
        host.send(1'b0, 8'h03, 1'b1);
        host.send(1'b1, 8'h3a, 1'b1);
        pins_check(32'h005a_41a8);
        cmd3(8'h04, 8'h3c, 8'hb2, 8'h03);
        // A data byte equal to a command code must stay a parameter
        host.send(1'b1, 8'h04, 1'b1);
        host.send(1'b1, 8'h55, 1'b1);
        rd_check(ra(epsc_pkg::REG_SRC_CFG), 32'h0055_b23c);
        host.send(1'b0, 8'h03, 1'b0);
        host.send(1'b1, 8'h07, 1'b0);
        pins_check(32'h555a_3cb2);
        for (int c = 1; c <= 2; c++) begin
            ahb(1'b1, ra(epsc_pkg::REG_CONTROL), c, rd);
            st_check(4'h1);
        end
        ignore_busy <= 1'b1;
        host.send(1'b0, 8'h03, 1'b1);
        host.send(1'b1, 8'h07, 1'b1);
        st_check(4'h5);
        pins_check(32'h555a_3cb2);
        ignore_busy <= 1'b0;
        ahb(1'b1, ra(epsc_pkg::REG_CONTROL), 32'h0000_0000, rd);
        ahb(1'b1, ra(epsc_pkg::REG_STATUS), 32'h0000_0004, rd);
        wait_ready();
        st_check(4'h0);
        @(posedge sys_clk);
        bus_width_strap <= 1'b1;
        three_wire      <= 1'b1;
        hw_reset_n      <= 1'b0;
        repeat (6) @(posedge sys_clk);
        hw_reset_n <= 1'b1;
        wait_ready();
        st_check(4'h2);
        pins_check(32'h0000_41a8);
        cmd3(8'h04, 8'ha5, 8'h5a, 8'h3e);
        cmd3(8'h01, 8'hc7, 8'h00, 8'h04);
        pins_check(32'h3e80_a55a);
        rd_check(ra(epsc_pkg::REG_BYTE_CNT), 32'h0000_0008);
        @(posedge sys_clk);
        reset <= 1'b1;
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
        wait_ready();
        pins_check(32'h0000_41a8);
        complete_run();
    end
endmodule
